//--- rtl/vit_consts.vh
/*
 constants for the vectored priority interrupt table.
 assumes inclusion by the single design file of the block.
*/
`ifndef VIT_CONSTS_VH
`define VIT_CONSTS_VH
// ------------------------------------------------
// table geometry
// ------------------------------------------------
`define VIT_NUM_VEC 82
`define VIT_VEC_W 7
`define VIT_LVL_W 2
`define VIT_RANK_W 3
`define VIT_ADDR_W 19
`define VIT_ENTRY_SHIFT 1
// ------------------------------------------------
// levels
// ------------------------------------------------
`define VIT_LVL_0 2'h0
`define VIT_LVL_1 2'h1
`define VIT_LVL_2 2'h2
`define VIT_LVL_3 2'h3
`define VIT_RANK_NONE 3'h0
`define VIT_RANK_LOW 3'h1
`define VIT_RANK_BASE 3'h2
`define VIT_NUM_RANK 6
// ------------------------------------------------
// fixed vector numbers
// ------------------------------------------------
`define VIT_VEC_ILLEGAL 7'h02
`define VIT_VEC_MISALIGN 7'h05
`define VIT_VEC_DBG_STEP 7'h06
`define VIT_VEC_DBG_BKPT 7'h07
`define VIT_VEC_DBG_TRACE 7'h09
`define VIT_VEC_DBG_RXF 7'h0B
`define VIT_VEC_SWI2 7'h0E
`define VIT_VEC_SWI1 7'h0F
`define VIT_VEC_SWI0 7'h10
`define VIT_VEC_LOW_VOLT 7'h14
`define VIT_VEC_FLASH_ERR 7'h16
`define VIT_VEC_FLASH_DONE 7'h17
`define VIT_VEC_SWI_LP 7'h51
`endif

//--- rtl/vit_vector_table.v
/*
 vectored priority interrupt table: pending capture, level clamping,
 arbitration by level then vector number, handler address from base.
 assumes the core acknowledges the vector it takes with a one-cycle pulse
 and that the base and level inputs come from core-side control registers.
*/
// Overview of operation
// R01: higher levels served fully before lower levels
// R02: equal level, smallest vector number wins
// R03: handler address is relative to vector base
// R04: entries 0 and 1 never dispatched
// R05: software puts jumps first, calls elsewhere
// R06: core exceptions vectors 2-5 fixed level 3
// R07: debug sources 6,7,9,10,11 levels 1-3
// R08: peripheral and pin levels limited 0-2
// R09: low-voltage request vector 20, levels 0-2
// R10: flash error vector 22, complete 23
// R11: two words per entry, 19-bit addresses
// R12: reserved vectors ignored; pending until acknowledged
`timescale 1ns/10ps
`default_nettype none
`include "vit_consts.vh"
module vit_vector_table #(
   parameter NUM_VEC = `VIT_NUM_VEC,
   parameter ADDR_W = `VIT_ADDR_W
) (
   input wire clk_sys,
   input wire rst,
   input wire [NUM_VEC-1:0] int_request,
   input wire [2*NUM_VEC-1:0] level_select,
   input wire [ADDR_W-1:0] vector_base_register,
   input wire int_ack,
   input wire [`VIT_VEC_W-1:0] int_ack_vector,
   output reg int_pending,
   output reg [`VIT_VEC_W-1:0] int_vector,
   output reg [`VIT_LVL_W-1:0] int_level,
   output reg int_low_priority,
   output reg [ADDR_W-1:0] handler_address
);
   // ------------------------------------------------
   // vector classification
   // ------------------------------------------------
   function is_reserved;
      input [`VIT_VEC_W-1:0] v;
      begin
         case (v)
            7'h00, 7'h01: is_reserved = 1'b1; // R04
            7'h08, 7'h0C, 7'h0D, 7'h13, 7'h24, 7'h25,
            7'h2C, 7'h33, 7'h46: is_reserved = 1'b1; // R12
            default: is_reserved = (v > `VIT_VEC_SWI_LP);
         endcase
      end
   endfunction

   // rank 0 = no request, 1 = below level 0, 2..5 hold levels 0..3
   function [`VIT_RANK_W-1:0] rank_of;
      input [`VIT_VEC_W-1:0] v;
      input [`VIT_LVL_W-1:0] sel;
      reg [`VIT_LVL_W-1:0] lvl;
      begin
         lvl = sel;
         if (v >= `VIT_VEC_ILLEGAL && v <= `VIT_VEC_MISALIGN) begin
            lvl = `VIT_LVL_3; // R06
         end else if (v >= `VIT_VEC_DBG_STEP && v <= `VIT_VEC_DBG_RXF) begin
            if (sel == `VIT_LVL_0) begin
               lvl = `VIT_LVL_1; // R07
            end
         end else if (v == `VIT_VEC_SWI2) begin
            lvl = `VIT_LVL_2; // R08
         end else if (v == `VIT_VEC_SWI1) begin
            lvl = `VIT_LVL_1; // R08
         end else if (v == `VIT_VEC_SWI0) begin
            lvl = `VIT_LVL_0; // R08
         end else if (sel == `VIT_LVL_3) begin
            lvl = `VIT_LVL_2; // R08 R09 R10
         end
         if (v == `VIT_VEC_SWI_LP) begin
            rank_of = 3'h1;
         end else begin
            rank_of = {1'b0, lvl} + 3'h2;
         end
      end
   endfunction

   // ------------------------------------------------
   // per-vector qualification and pending flags
   // ------------------------------------------------
   wire [NUM_VEC-1:0] valid_vec;
   wire [NUM_VEC-1:0] clr_vec;
   wire [NUM_VEC-1:0] set_vec;
   wire [NUM_VEC-1:0] pending;
   wire [`VIT_RANK_W*NUM_VEC-1:0] rank_flat;
   genvar g;
   generate
      for (g = 0; g < NUM_VEC; g = g + 1) begin : gen_vec
         localparam [`VIT_VEC_W-1:0] VEC_NUM = g;
         reg pend_bit;
         // reserved slots never pend
         assign valid_vec[g] = ~is_reserved(VEC_NUM); // R04 R12
         // acknowledge of this vector by the core
         assign clr_vec[g] = int_ack && (int_ack_vector == VEC_NUM); // R12
         // new request, qualified
         assign set_vec[g] = int_request[g] & valid_vec[g];
         // clamped rank of this vector
         assign rank_flat[`VIT_RANK_W*g +: `VIT_RANK_W] =
            rank_of(VEC_NUM, level_select[2*g +: 2]); // R06 R07 R08 R09 R10
         // set wins over clear; held until acknowledged
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               pend_bit <= 1'b0;
            end else begin
               pend_bit <= (pend_bit & ~clr_vec[g]) | set_vec[g]; // R12
            end
         end
         assign pending[g] = pend_bit;
      end
   endgenerate

   // ------------------------------------------------
   // ranks that have work pending
   // ------------------------------------------------
   reg [`VIT_NUM_RANK-1:0] rank_any;
   integer i;
   always @* begin
      rank_any = {`VIT_NUM_RANK{1'b0}};
      for (i = 0; i < NUM_VEC; i = i + 1) begin
         if (pending[i]) begin
            rank_any[rank_flat[`VIT_RANK_W*i +: `VIT_RANK_W]] = 1'b1;
         end
      end
   end

   // ------------------------------------------------
   // arbitration: highest rank, then lowest vector
   // ------------------------------------------------
   reg [`VIT_RANK_W-1:0] best_rank;
   integer r;
   always @* begin
      best_rank = `VIT_RANK_NONE;
      // higher ranks overwrite lower ones
      for (r = 1; r < `VIT_NUM_RANK; r = r + 1) begin
         if (rank_any[r]) begin
            best_rank = r[`VIT_RANK_W-1:0]; // R01
         end
      end
   end

   reg [`VIT_VEC_W-1:0] best_vec;
   reg found;
   integer j;
   always @* begin
      best_vec = {`VIT_VEC_W{1'b0}};
      found = 1'b0;
      // first hit at the winning rank is the lowest vector
      for (j = 0; j < NUM_VEC; j = j + 1) begin
         if (!found && pending[j] &&
            (rank_flat[`VIT_RANK_W*j +: `VIT_RANK_W] == best_rank)) begin // R02
            best_vec = j[`VIT_VEC_W-1:0];
            found = 1'b1;
         end
      end
   end

   // ------------------------------------------------
   // next dispatch values
   // ------------------------------------------------
   wire [ADDR_W-1:0] entry_offset;
   wire [`VIT_RANK_W-1:0] lvl_rank;
   reg next_int_pending;
   reg [`VIT_VEC_W-1:0] next_int_vector;
   reg [`VIT_LVL_W-1:0] next_int_level;
   reg next_int_low_priority;
   reg [ADDR_W-1:0] next_handler_address;
   // two words per entry
   assign entry_offset = {{(ADDR_W-`VIT_VEC_W){1'b0}}, best_vec} << `VIT_ENTRY_SHIFT; // R11
   assign lvl_rank = best_rank - `VIT_RANK_BASE;
   always @* begin
      next_int_pending = (best_rank != `VIT_RANK_NONE);
      next_int_vector = best_vec;
      next_int_low_priority = (best_rank == `VIT_RANK_LOW);
      if (best_rank > `VIT_RANK_LOW) begin
         next_int_level = lvl_rank[`VIT_LVL_W-1:0];
      end else begin
         next_int_level = `VIT_LVL_0;
      end
      // address wraps within the 19-bit (ADDR_W) address range
      next_handler_address = vector_base_register + entry_offset; // R03 R11
   end

   // ------------------------------------------------
   // dispatch status outputs
   // ------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         int_pending <= 1'b0;
         int_vector <= {`VIT_VEC_W{1'b0}};
         int_level <= `VIT_LVL_0;
         int_low_priority <= 1'b0;
      end else begin
         int_pending <= next_int_pending;
         int_vector <= next_int_vector;
         int_level <= next_int_level;
         int_low_priority <= next_int_low_priority;
      end
   end

   // ------------------------------------------------
   // handler address output
   // ------------------------------------------------
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         handler_address <= {ADDR_W{1'b0}};
      end else begin
         handler_address <= next_handler_address; // R03
      end
   end
endmodule // vit_vector_table
`default_nettype wire

//--- testbench/test_vit_vector_table.sv
/* random request bursts, dispatch order and handler checked; assumes vit_core_model */
`timescale 1ns/10ps
`default_nettype none
module test_vit_vector_table;
   logic clk_sys = 0, rst = 1, int_ack, int_low_priority, int_pending, fetch_is_call;
   logic [81:0] req = 0;
   logic [163:0] sel = 0;
   logic [18:0] base = 0, addr;
   logic [6:0] ack_vec, vec;
   logic [1:0] lvl;
   logic [3:0] wait_cycles = 4'h2;
   logic [28:0] q[$];
   int miscompares = 0, tests_run = 0, l, v, t;
   always #4 clk_sys = ~clk_sys;
   vit_vector_table DUT (.clk_sys, .rst, .int_request(req), .level_select(sel),
      .vector_base_register(base), .int_ack, .int_ack_vector(ack_vec), .int_pending,
      .int_vector(vec), .int_level(lvl), .int_low_priority, .handler_address(addr));
   vit_core_model core (.clk_sys, .rst, .int_pending, .int_vector(vec), .wait_cycles, .int_ack,
      .int_ack_vector(ack_vec), .fetch_is_call);
   function automatic int rank(int v, logic [1:0] s);
      if (v < 2 || v > 81 || v inside {8, 12, 13, 19, 36, 37, 44, 51, 70}) return 9;
      if (v < 6) return 3;
      if (v inside {6, 7, 9, 10, 11}) return s == 0 ? 1 : s;
      if (v inside {[14:16]}) return 16 - v;
      if (v == 81) return -1;
      return s == 3 ? 2 : s;
   endfunction
   task automatic chk(logic [28:0] e, logic [28:0] g);
      tests_run++;
      if (e !== g) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic test_done;
      if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   always @(negedge clk_sys)
      if (int_ack === 1'b1) begin
         chk(q.size() ? q.pop_front() : 29'h1FFFFFFF, {lvl, int_low_priority, ack_vec, addr});
         chk(29'h1, {28'h0, fetch_is_call});
      end
   initial begin
      l = $urandom(32'h58F0);
      repeat (3) @(posedge clk_sys);
      #1 rst = 0;
      for (t = 0; t < 40; t++) begin
         @(posedge clk_sys);
         #1 base = 19'($urandom);
         sel = 164'({$urandom, $urandom, $urandom, $urandom, $urandom, $urandom});
         wait_cycles = 4'(2 + $urandom % 8);
         req = 82'({$urandom, $urandom, $urandom} & {$urandom, $urandom, $urandom});
         for (l = 3; l >= -1; l--)
            for (v = 0; v < 82; v++)
               if (req[v] && rank(v, sel[2*v+:2]) == l)
                  q.push_back({l < 0 ? 2'h0 : 2'(l), l < 0, 7'(v), 19'(base + 2 * v)});
         @(posedge clk_sys);
         #1 req = 0;
         for (v = 0; v < 1000 && q.size() > 0; v++) @(posedge clk_sys);
         if (q.size() > 0) begin
            miscompares++;
            test_done;
         end
         repeat (8) @(posedge clk_sys);
      end
      test_done;
   end
endmodule // test_vit_vector_table
`default_nettype wire

//--- testbench/vit_core_model.sv
/* core model: acks the shown winner; assumes the table's outputs are registered */
`timescale 1ns/10ps
`default_nettype none
module vit_core_model (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic int_pending,
   input wire logic [6:0] int_vector,
   input wire logic [3:0] wait_cycles,
   output logic int_ack,
   output logic [6:0] int_ack_vector,
   output logic fetch_is_call
);
   logic [3:0] n;
   logic [81:0] entry_is_call = {{80{1'b1}}, 2'b00};
   // table fill: jumps over the reset overlays, calls elsewhere
   assign fetch_is_call = entry_is_call[int_ack_vector];
   // wait_cycles of one or more skips the stale winner after an ack
   always @(posedge clk_sys or posedge rst)
      if (rst) {int_ack, int_ack_vector, n} <= 0;
      else if (int_ack) {int_ack, int_ack_vector, n} <= {1'b0, ~int_ack_vector, 4'h0};
      else if (int_pending && n >= wait_cycles) {int_ack, int_ack_vector} <= {1'b1, int_vector};
      else n <= n + 4'h1;
endmodule // vit_core_model
`default_nettype wire

//--- testbench/vit_vector_table_props.sv
/* checker on the table outputs; assumes one clock with async high rst */
`timescale 1ns/10ps
`default_nettype none
module vit_props #(parameter NUM_VEC = 82, parameter ADDR_W = 19) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [NUM_VEC-1:0] int_request,
   input wire logic [ADDR_W-1:0] vector_base_register,
   input wire logic int_pending,
   input wire logic [6:0] int_vector,
   input wire logic [1:0] int_level,
   input wire logic int_low_priority,
   input wire logic [ADDR_W-1:0] handler_address
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   AST_ADDR: assert property (int_pending && $stable(vector_base_register) |->
      handler_address == ADDR_W'(vector_base_register + 2 * int_vector)) else $error("address");
   AST_RSV: assert property (int_pending |-> int_vector > 1 && int_vector < NUM_VEC)
      else $error("reserved vector");
   AST_EXC: assert property (int_pending && int_vector < 6 |-> int_level == 3)
      else $error("exception level");
   AST_DBG: assert property (int_pending && int_vector inside {6, 7, 9, 10, 11} |->
      int_level != 0) else $error("debug level");
   AST_SWI: assert property (int_pending && int_vector inside {[14:16]} |->
      int_level == 16 - int_vector) else $error("soft level");
   AST_PER: assert property (int_pending && int_vector > 16 |-> int_level < 3)
      else $error("source level");
   AST_LOWP: assert property (int_low_priority |-> int_vector == 81 && int_level == 0)
      else $error("low priority");
   AST_TOP: assert property (int_request[2] |-> ##2 int_pending && int_vector == 2)
      else $error("top winner");
   AST_FLASH: assert property (int_request[22] |-> ##2 int_pending)
      else $error("not pending");
endmodule // vit_props
bind vit_vector_table vit_props #(.NUM_VEC(NUM_VEC), .ADDR_W(ADDR_W)) u_props (.clk_sys, .rst,
   .int_request, .vector_base_register, .int_pending, .int_vector, .int_level, .int_low_priority,
   .handler_address);
`default_nettype wire
